// file: rtl/tmw_timer16_waveform.sv
// Purpose: 16-bit timer waveform mode and compare output control
// Assumes: One clock, tick input is a one-cycle enable on that clock
// Notes:   Capture pin is synchronised; output enable is active low
`timescale 1ns/100ps
module tmw_timer16_waveform (
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_sys_rst,
  // Timer tick enable
  input  wire logic       i_timer_tick_enable,
  // Register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Capture input pin
  input  wire logic       i_capture_input_pin,
  // Waveform pins
  output logic            o_channel_a_waveform_pin,
  output logic            o_channel_a_waveform_oe_n,
  output logic            o_channel_b_waveform_pin,
  output logic            o_channel_b_waveform_oe_n,
  // Status
  output logic [2:0]      o_flags
);
  tmw_pkg::tmw_state_type   r;
  tmw_pkg::tmw_state_type   next_r;
  tmw_pkg::tmw_bus_type     bus;
  tmw_pkg::tmw_class_type   cls;
  tmw_pkg::tmw_topsrc_type  topsrc;
  logic [3:0]               wgm;
  logic [15:0]              top;
  logic [1:0]               com [2];
  logic [15:0]              cmp [2];
  logic [1:0]               hit;
  logic [1:0]               connected;
  logic                     at_top;
  logic                     at_bottom;
  logic                     immediate;
  logic                     load_now;
  logic                     ovf_now;
  logic                     cap_disabled;
  logic                     cap_event;

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  // ==========================================================
  // Mode decode
  assign wgm = {r.ctrl_b[tmw_pkg::CTRL_B_WGM_POS +: 2],
                r.ctrl_a[1:0]};
  assign com[0] = r.ctrl_a[tmw_pkg::CTRL_A_MODE_A_POS +: 2];
  assign com[1] = r.ctrl_a[tmw_pkg::CTRL_A_MODE_B_POS +: 2];
  assign cmp[0] = r.cmpa;
  assign cmp[1] = r.cmpb;

  always_comb begin
    cls    = tmw_pkg::CLS_RSVD;
    topsrc = tmw_pkg::TOP_FIXED;
    top    = tmw_pkg::MAX_VAL;
    case (wgm)
      4'h0: cls = tmw_pkg::CLS_NORMAL;
      4'h1, 4'h2, 4'h3: cls = tmw_pkg::CLS_PHASE;
      4'h4: begin
        cls    = tmw_pkg::CLS_CTC;
        topsrc = tmw_pkg::TOP_CMPA;
      end
      4'h5, 4'h6, 4'h7: cls = tmw_pkg::CLS_FAST;
      4'h8: begin
        cls    = tmw_pkg::CLS_PFC;
        topsrc = tmw_pkg::TOP_CAP;
      end
      4'h9: begin
        cls    = tmw_pkg::CLS_PFC;
        topsrc = tmw_pkg::TOP_CMPA;
      end
      4'ha: begin
        cls    = tmw_pkg::CLS_PHASE;
        topsrc = tmw_pkg::TOP_CAP;
      end
      4'hb: begin
        cls    = tmw_pkg::CLS_PHASE;
        topsrc = tmw_pkg::TOP_CMPA;
      end
      4'hc: begin
        cls    = tmw_pkg::CLS_CTC;
        topsrc = tmw_pkg::TOP_CAP;
      end
      4'he: begin
        cls    = tmw_pkg::CLS_FAST;
        topsrc = tmw_pkg::TOP_CAP;
      end
      4'hf: begin
        cls    = tmw_pkg::CLS_FAST;
        topsrc = tmw_pkg::TOP_CMPA;
      end
      default: cls = tmw_pkg::CLS_RSVD;
    endcase
    case (wgm[1:0])
      2'b01: top = tmw_pkg::TOP_8BIT;
      2'b10: top = tmw_pkg::TOP_9BIT;
      default: top = tmw_pkg::TOP_10BIT;
    endcase
    if (wgm == 4'h0) begin
      top = tmw_pkg::MAX_VAL;
    end
    if (topsrc == tmw_pkg::TOP_CAP) begin
      top = r.cap;
    end else if (topsrc == tmw_pkg::TOP_CMPA) begin
      top = r.cmpa;
    end
  end

  assign at_top       = (r.cnt == top);
  assign at_bottom    = (r.cnt == tmw_pkg::BOTTOM_VAL);
  assign immediate    = (cls == tmw_pkg::CLS_NORMAL) ||
                        (cls == tmw_pkg::CLS_CTC);
  assign cap_disabled = (topsrc == tmw_pkg::TOP_CAP);
  assign cap_event    = !cap_disabled &&
                        (r.cap_sync2[0] != r.cap_prev) &&
                        (r.cap_sync2[0] == r.cap_edge_sel);

  // Buffer load and overflow instants, decided on the tick at the limit
  always_comb begin
    load_now = 1'b0;
    ovf_now  = 1'b0;
    case (cls)
      tmw_pkg::CLS_NORMAL, tmw_pkg::CLS_CTC: begin
        ovf_now = (r.cnt == tmw_pkg::MAX_VAL);
      end
      tmw_pkg::CLS_FAST: begin
        load_now = at_top;
        ovf_now  = at_top;
      end
      tmw_pkg::CLS_PHASE: begin
        load_now = at_top && !r.down;
        ovf_now  = at_bottom && r.down;
      end
      tmw_pkg::CLS_PFC: begin
        load_now = at_bottom && r.down;
        ovf_now  = load_now;
      end
      default: begin
        load_now = 1'b0;
        ovf_now  = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Compare output per channel
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    assign hit[ch] = (r.cnt == cmp[ch]) && !r.block_match;
    // Mode value 1 in PWM classes only drives channel A in some modes
    always_comb begin
      connected[ch] = (com[ch] != 2'b00);
      if (com[ch] == 2'b01) begin
        if (cls == tmw_pkg::CLS_FAST) begin
          connected[ch] = (ch == 0) && wgm[3:1] == 3'b111;
        end else if (cls == tmw_pkg::CLS_PHASE ||
                     cls == tmw_pkg::CLS_PFC) begin
          connected[ch] = (ch == 0) &&
                          (wgm == 4'h9 || wgm == 4'hb);
        end
      end
      if (cls == tmw_pkg::CLS_RSVD) begin
        connected[ch] = 1'b0;
      end
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_r        = r;
    next_r.rdata  = 8'h00;
    next_r.block_match = 1'b0;
    next_r.cap_sync1 = {r.cap_sync1[0], i_capture_input_pin};
    next_r.cap_sync2 = {r.cap_sync2[0], r.cap_sync1[1]};
    next_r.cap_prev  = r.cap_sync2[0];
    if (cap_event) begin
      next_r.cap = r.cnt;
    end
    if (i_timer_tick_enable) begin
      // Counting sequence
      case (cls)
        tmw_pkg::CLS_PHASE, tmw_pkg::CLS_PFC: begin
          if (!r.down && at_top) begin
            next_r.down = 1'b1;
            next_r.cnt  = r.cnt - 16'h0001;
          end else if (r.down && at_bottom) begin
            next_r.down = 1'b0;
            next_r.cnt  = r.cnt + 16'h0001;
          end else if (r.down) begin
            next_r.cnt  = r.cnt - 16'h0001;
          end else begin
            next_r.cnt  = r.cnt + 16'h0001;
          end
        end
        tmw_pkg::CLS_RSVD: next_r.cnt = r.cnt;
        default: begin
          next_r.down = 1'b0;
          next_r.cnt  = at_top ? tmw_pkg::BOTTOM_VAL
                               : r.cnt + 16'h0001;
        end
      endcase
      if (load_now) begin
        next_r.cmpa = r.cmpa_buf;
        next_r.cmpb = r.cmpb_buf;
      end
      if (ovf_now) begin
        next_r.flags[tmw_pkg::FLAG_OVF_POS] = 1'b1;
      end
      if (hit[0]) begin
        next_r.flags[tmw_pkg::FLAG_CMPA_POS] = 1'b1;
      end
      if (hit[1]) begin
        next_r.flags[tmw_pkg::FLAG_CMPB_POS] = 1'b1;
      end
      // Waveform actions
      for (int ch = 0; ch < 2; ch++) begin
        case (cls)
          tmw_pkg::CLS_NORMAL, tmw_pkg::CLS_CTC: begin
            if (hit[ch]) begin
              case (com[ch])
                2'b01: next_r.wave[ch] = !r.wave[ch];
                2'b10: next_r.wave[ch] = 1'b0;
                2'b11: next_r.wave[ch] = 1'b1;
                default: next_r.wave[ch] = r.wave[ch];
              endcase
            end
          end
          tmw_pkg::CLS_FAST: begin
            if (com[ch][1]) begin
              if (at_top) begin
                next_r.wave[ch] = !com[ch][0];
              end else if (hit[ch] && cmp[ch] != top) begin
                next_r.wave[ch] = com[ch][0];
              end
            end else if (com[ch] == 2'b01 && hit[ch]) begin
              next_r.wave[ch] = !r.wave[ch];
            end
          end
          tmw_pkg::CLS_PHASE, tmw_pkg::CLS_PFC: begin
            if (hit[ch]) begin
              if (com[ch][1]) begin
                next_r.wave[ch] = com[ch][0] ^ r.down;
              end else if (com[ch] == 2'b01) begin
                next_r.wave[ch] = !r.wave[ch];
              end
            end
          end
          default: next_r.wave[ch] = r.wave[ch];
        endcase
      end
    end
    // Software access; a hardware flag set wins over a clear
    if (bus.wr) begin
      case (bus.addr)
        tmw_pkg::ADDR_CTRL_A:
          next_r.ctrl_a = bus.wdata & tmw_pkg::CTRL_A_WMASK;
        tmw_pkg::ADDR_CTRL_B: begin
          next_r.ctrl_b = bus.wdata & tmw_pkg::CTRL_B_WMASK;
          next_r.cap_edge_sel = bus.wdata[6];
        end
        tmw_pkg::ADDR_CNT_L, tmw_pkg::ADDR_CAP_L,
        tmw_pkg::ADDR_CMPA_L, tmw_pkg::ADDR_CMPB_L: begin
          if (bus.addr == tmw_pkg::ADDR_CNT_L) begin
            next_r.cnt = {r.temp, bus.wdata};
            next_r.block_match = 1'b1;
          end else if (bus.addr == tmw_pkg::ADDR_CAP_L) begin
            next_r.cap = {r.temp, bus.wdata};
          end else if (bus.addr == tmw_pkg::ADDR_CMPA_L) begin
            next_r.cmpa_buf = {r.temp, bus.wdata};
            if (immediate) begin
              next_r.cmpa = {r.temp, bus.wdata};
            end
          end else begin
            next_r.cmpb_buf = {r.temp, bus.wdata};
            if (immediate) begin
              next_r.cmpb = {r.temp, bus.wdata};
            end
          end
        end
        tmw_pkg::ADDR_CNT_H, tmw_pkg::ADDR_CAP_H,
        tmw_pkg::ADDR_CMPA_H, tmw_pkg::ADDR_CMPB_H:
          next_r.temp = bus.wdata;
        tmw_pkg::ADDR_FLAGS:
          next_r.flags = next_r.flags & ~(bus.wdata[2:0] & ~(
            {hit[1], hit[0], ovf_now} & {3{i_timer_tick_enable}}));
        tmw_pkg::ADDR_PIN_CTRL: next_r.dir = bus.wdata[1:0];
        default: next_r.temp = r.temp;
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        tmw_pkg::ADDR_CTRL_A: next_r.rdata = r.ctrl_a;
        tmw_pkg::ADDR_CTRL_B:
          next_r.rdata = r.ctrl_b | {1'b0, r.cap_edge_sel, 6'h00};
        tmw_pkg::ADDR_CNT_L: begin
          next_r.rdata = r.cnt[7:0];
          next_r.temp  = r.cnt[15:8];
        end
        tmw_pkg::ADDR_CAP_L: begin
          next_r.rdata = r.cap[7:0];
          next_r.temp  = r.cap[15:8];
        end
        tmw_pkg::ADDR_CMPA_L: next_r.rdata = r.cmpa_buf[7:0];
        tmw_pkg::ADDR_CMPA_H: next_r.rdata = r.cmpa_buf[15:8];
        tmw_pkg::ADDR_CMPB_L: next_r.rdata = r.cmpb_buf[7:0];
        tmw_pkg::ADDR_CMPB_H: next_r.rdata = r.cmpb_buf[15:8];
        tmw_pkg::ADDR_CNT_H, tmw_pkg::ADDR_CAP_H:
          next_r.rdata = r.temp;
        tmw_pkg::ADDR_FLAGS: next_r.rdata = {5'h00, r.flags};
        tmw_pkg::ADDR_PIN_CTRL: next_r.rdata = {6'h00, r.dir};
        default: next_r.rdata = 8'h00;
      endcase
    end
    // Pins follow the settled waveform; taking next_r.wave keeps them registered with no lag behind wave
    for (int ch = 0; ch < 2; ch++) begin
      next_r.pin_out[ch]  = connected[ch] ? next_r.wave[ch] : 1'b0;
      next_r.pin_oe_n[ch] = !(connected[ch] && r.dir[ch]);
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      r          <= '0;
      r.pin_oe_n <= 2'b11;
    end else begin
      r <= next_r;
    end
  end

  assign o_rdata                   = r.rdata;
  assign o_channel_a_waveform_pin  = r.pin_out[0];
  assign o_channel_a_waveform_oe_n = r.pin_oe_n[0];
  assign o_channel_b_waveform_pin  = r.pin_out[1];
  assign o_channel_b_waveform_oe_n = r.pin_oe_n[1];
  assign o_flags                   = r.flags;
endmodule // tmw_timer16_waveform

// file: rtl/tmw_pkg.sv
// Purpose: Constants and carrier types for the 16-bit timer waveform block
// Assumes: 8-bit register port, word index addressing
// Notes:   Offsets are register indices on the plain register port
package tmw_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_CTRL_A   = 8'h80;
  localparam logic [7:0] ADDR_CTRL_B   = 8'h81;
  localparam logic [7:0] ADDR_CNT_L    = 8'h84;
  localparam logic [7:0] ADDR_CNT_H    = 8'h85;
  localparam logic [7:0] ADDR_CAP_L    = 8'h86;
  localparam logic [7:0] ADDR_CAP_H    = 8'h87;
  localparam logic [7:0] ADDR_CMPA_L   = 8'h88;
  localparam logic [7:0] ADDR_CMPA_H   = 8'h89;
  localparam logic [7:0] ADDR_CMPB_L   = 8'h8a;
  localparam logic [7:0] ADDR_CMPB_H   = 8'h8b;
  localparam logic [7:0] ADDR_FLAGS    = 8'h96;
  localparam logic [7:0] ADDR_PIN_CTRL = 8'h97;
  // ==========================================================
  // Field layout
  localparam int         CTRL_A_MODE_A_POS = 6;
  localparam int         CTRL_A_MODE_B_POS = 4;
  localparam logic [7:0] CTRL_A_WMASK      = 8'hf3;
  localparam int         CTRL_B_WGM_POS    = 3;
  localparam logic [7:0] CTRL_B_WMASK      = 8'h18;
  localparam int         FLAG_OVF_POS      = 0;
  localparam int         FLAG_CMPA_POS     = 1;
  localparam int         FLAG_CMPB_POS     = 2;
  localparam logic [7:0] REG_RESET         = 8'h00;
  // ==========================================================
  // Counting limits
  localparam logic [15:0] BOTTOM_VAL = 16'h0000;
  localparam logic [15:0] MAX_VAL    = 16'hffff;
  localparam logic [15:0] TOP_8BIT   = 16'h00ff;
  localparam logic [15:0] TOP_9BIT   = 16'h01ff;
  localparam logic [15:0] TOP_10BIT  = 16'h03ff;
  // ==========================================================
  // Mode classes
  typedef enum logic [2:0] {
    CLS_NORMAL = 3'b000,
    CLS_CTC    = 3'b001,
    CLS_FAST   = 3'b010,
    CLS_PHASE  = 3'b011,
    CLS_PFC    = 3'b100,
    CLS_RSVD   = 3'b101
  } tmw_class_type;

  typedef enum logic [1:0] {
    TOP_FIXED = 2'b00,
    TOP_CAP   = 2'b01,
    TOP_CMPA  = 2'b10
  } tmw_topsrc_type;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tmw_bus_type;

  // Whole block state
  typedef struct packed {
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic [15:0] cnt;
    logic        down;
    logic [15:0] cap;
    logic [15:0] cmpa_buf;
    logic [15:0] cmpb_buf;
    logic [15:0] cmpa;
    logic [15:0] cmpb;
    logic [7:0]  temp;
    logic [2:0]  flags;
    logic [1:0]  dir;
    logic [1:0]  wave;
    logic [1:0]  pin_out;
    logic [1:0]  pin_oe_n;
    logic [1:0]  cap_sync1;
    logic [1:0]  cap_sync2;
    logic        cap_prev;
    logic        block_match;
    logic        cap_edge_sel;
    logic [7:0]  rdata;
  } tmw_state_type;
endpackage

// file: test/tmw_timer16_waveform_sva.sv
// Purpose: Port-level checks for the timer waveform block
// Assumes: A shadow of control writes mirrors the register masks
// Notes:   Pin checks wait three quiet cycles after any write
`timescale 1ns/100ps
module tmw_timer16_waveform_sva (
  // Clock and reset
  input wire logic       i_core_clk,
  input wire logic       i_sys_rst,
  // Register port and tick
  input wire logic       i_timer_tick_enable,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  // Pins and flags
  input wire logic       o_channel_a_waveform_pin,
  input wire logic       o_channel_a_waveform_oe_n,
  input wire logic       o_channel_b_waveform_pin,
  input wire logic       o_channel_b_waveform_oe_n,
  input wire logic [2:0] o_flags
);
  // ====================
  // Configuration shadow
  logic [7:0] ca;
  logic [7:0] cb;
  logic [1:0] dr;
  logic [1:0] quiet;
  logic [3:0] md;
  logic       pwm;
  logic       con_a;
  logic       con_b;
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ca    <= 8'h00;
      cb    <= 8'h00;
      dr    <= 2'h0;
      quiet <= 2'h0;
    end else begin
      if (i_wr && i_addr == tmw_pkg::ADDR_CTRL_A) ca <= i_wdata & 8'hf3;
      if (i_wr && i_addr == tmw_pkg::ADDR_CTRL_B) cb <= i_wdata & 8'h58;
      if (i_wr && i_addr == tmw_pkg::ADDR_PIN_CTRL) dr <= i_wdata[1:0];
      if (i_wr) quiet <= 2'h0;
      else if (quiet != 2'h3) quiet <= quiet + 2'h1;
    end
  end
  // Toggle value 1 only reaches pin A in the four modes that allow it
  always_comb begin
    md    = {cb[4:3], ca[1:0]};
    pwm   = !(md inside {4'h0, 4'h4, 4'hc, 4'hd});
    con_a = ca[7:6] != 2'h0 && md != 4'hd && (ca[7:6] != 2'h1 || !pwm ||
            md inside {4'h9, 4'hb, 4'he, 4'hf});
    con_b = ca[5:4] != 2'h0 && md != 4'hd && (ca[5:4] != 2'h1 || !pwm);
  end
  // ====================
  // Properties
  default clocking cb_main @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  sequence s_rd_a;
    i_rd && i_addr == tmw_pkg::ADDR_CTRL_A;
  endsequence
  sequence s_rd_b;
    i_rd && i_addr == tmw_pkg::ADDR_CTRL_B;
  endsequence
  sequence s_rd_unmapped;
    i_rd && (i_addr < 8'h80 || i_addr > 8'h97);
  endsequence
  a_ctrla_readback: assert property (
    s_rd_a |=> o_rdata == $past(ca)) else $error("control A readback");
  a_ctrlb_mask: assert property (
    s_rd_b |=> o_rdata == $past(cb)) else $error("control B readback");
  a_unmapped_zero: assert property (
    s_rd_unmapped |=> o_rdata == 8'h00) else $error("unmapped read");
  a_rdata_idle: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00) else $error("read data not idle");
  a_oe_a_connect: assert property (
    quiet == 2'h3 |-> o_channel_a_waveform_oe_n == !(con_a && dr[0]))
    else $error("pin A enable wrong");
  a_oe_b_connect: assert property (
    quiet == 2'h3 |-> o_channel_b_waveform_oe_n == !(con_b && dr[1]))
    else $error("pin B enable wrong");
  a_pin_a_idle: assert property (
    quiet == 2'h3 && !con_a |-> !o_channel_a_waveform_pin)
    else $error("pin A level while disconnected");
  a_pin_b_idle: assert property (
    quiet == 2'h3 && !con_b |-> !o_channel_b_waveform_pin)
    else $error("pin B level while disconnected");
  a_flag_on_tick: assert property (
    (o_flags & ~$past(o_flags)) != 3'h0 |-> $past(i_timer_tick_enable))
    else $error("flag set without tick");
  a_pin_on_tick: assert property (
    quiet == 2'h3 && $changed(o_channel_a_waveform_pin) |->
    $past(i_timer_tick_enable) || $past(i_timer_tick_enable, 2))
    else $error("pin A moved without tick");
endmodule // tmw_timer16_waveform_sva

bind tmw_timer16_waveform tmw_timer16_waveform_sva tmw_timer16_waveform_sva_i (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
  .i_timer_tick_enable(i_timer_tick_enable), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_channel_a_waveform_pin(o_channel_a_waveform_pin),
  .o_channel_a_waveform_oe_n(o_channel_a_waveform_oe_n),
  .o_channel_b_waveform_pin(o_channel_b_waveform_pin),
  .o_channel_b_waveform_oe_n(o_channel_b_waveform_oe_n),
  .o_flags(o_flags)
);

// file: test/tmw_load_model.sv
// Purpose: Load circuitry hanging on the two waveform pins
// Assumes: Each pad has a pull-down on the board
// Notes:   Counts clocks with pad A high to measure duty
`timescale 1ns/100ps
module tmw_load_model (
  // Clock
  input  wire logic        i_core_clk,
  // Waveform pins
  input  wire logic        i_pin_a,
  input  wire logic        i_oe_a_n,
  input  wire logic        i_pin_b,
  input  wire logic        i_oe_b_n,
  // Pad levels and duty count
  output logic             o_pad_a,
  output logic             o_pad_b,
  output logic [15:0]      o_high_a
);
  // A released pad falls to the pull-down, never keeps the last level
  assign o_pad_a = i_oe_a_n ? 1'b0 : i_pin_a;
  assign o_pad_b = i_oe_b_n ? 1'b0 : i_pin_b;
  initial o_high_a = 16'h0000;
  always @(posedge i_core_clk) begin
    o_high_a <= o_high_a + {15'h0000, o_pad_a};
  end
endmodule // tmw_load_model

// file: test/tmw_timer16_waveform_bench.sv
// Purpose: Self-checking bench for the timer waveform block
// Assumes: Tick held high while measuring, one count per clock
// Notes:   Duty is counted over whole periods so phase cannot skew it
`timescale 1ns/100ps
module tmw_timer16_waveform_bench;
  typedef struct packed {
    logic [7:0]  ca;
    logic [7:0]  cb;
    logic [1:0]  dir;
    logic [7:0]  cmp;
    logic [11:0] win;
    logic [1:0]  oe_n;
    logic [11:0] hi;
  } tmw_row_type;
  // ====================
  logic        i_core_clk          = 1'b0;
  logic        i_sys_rst           = 1'b1;
  logic        i_timer_tick_enable = 1'b0;
  logic [7:0]  i_addr              = 8'h00;
  logic [7:0]  i_wdata             = 8'h00;
  logic        i_wr                = 1'b0;
  logic        i_rd                = 1'b0;
  logic [7:0]  o_rdata;
  logic        pin_a;
  logic        oe_a_n;
  logic        pin_b;
  logic        oe_b_n;
  logic [2:0]  o_flags;
  logic        pad_a;
  logic        pad_b;
  logic [15:0] high_a;
  logic [15:0] h0;
  logic [7:0]  rv;
  int          miscompares = 0;
  int          tests_run   = 0;
  int          cycles      = 0;
  tmw_row_type rows [18] = '{
    '{8'h00,8'h00,2'h3,8'h00,12'h000,2'h3,12'd0},
    '{8'h40,8'h00,2'h3,8'h00,12'h000,2'h1,12'd0},
    '{8'h10,8'h00,2'h3,8'h00,12'h000,2'h2,12'd0},
    '{8'hc0,8'h00,2'h0,8'h00,12'h000,2'h3,12'd0},
    '{8'h51,8'h08,2'h3,8'h00,12'h000,2'h3,12'd0},
    '{8'h52,8'h18,2'h3,8'h00,12'h000,2'h1,12'd0},
    '{8'h53,8'h10,2'h3,8'h00,12'h000,2'h1,12'd0},
    '{8'h52,8'h10,2'h3,8'h00,12'h000,2'h3,12'd0},
    '{8'hf1,8'h18,2'h3,8'h00,12'h000,2'h3,12'd0},
    '{8'ha1,8'h08,2'h3,8'h10,12'd2048,2'h0,12'd136},
    '{8'ha2,8'h08,2'h3,8'h10,12'd2048,2'h0,12'd68},
    '{8'ha3,8'h08,2'h3,8'h10,12'd2048,2'h0,12'd34},
    '{8'he1,8'h08,2'h3,8'h10,12'd2048,2'h0,12'd1912},
    '{8'ha1,8'h08,2'h3,8'hff,12'd2048,2'h0,12'd2048},
    '{8'ha1,8'h00,2'h3,8'h10,12'd2040,2'h0,12'd128},
    '{8'he1,8'h00,2'h3,8'h10,12'd2040,2'h0,12'd1912},
    '{8'h43,8'h10,2'h3,8'h10,12'd2048,2'h1,12'd1024},
    '{8'h41,8'h10,2'h3,8'h10,12'd2048,2'h1,12'd1024}};

  tmw_timer16_waveform tmw_timer16_waveform_i (
    .i_core_clk               (i_core_clk),
    .i_sys_rst                (i_sys_rst),
    .i_timer_tick_enable      (i_timer_tick_enable),
    .i_addr                   (i_addr),
    .i_wdata                  (i_wdata),
    .i_wr                     (i_wr),
    .i_rd                     (i_rd),
    .o_rdata                  (o_rdata),
    .i_capture_input_pin      (1'b0),
    .o_channel_a_waveform_pin (pin_a),
    .o_channel_a_waveform_oe_n(oe_a_n),
    .o_channel_b_waveform_pin (pin_b),
    .o_channel_b_waveform_oe_n(oe_b_n),
    .o_flags                  (o_flags)
  );
  tmw_load_model tmw_load_model_i (
    .i_core_clk(i_core_clk),
    .i_pin_a   (pin_a),
    .i_oe_a_n  (oe_a_n),
    .i_pin_b   (pin_b),
    .i_oe_b_n  (oe_b_n),
    .o_pad_a   (pad_a),
    .o_pad_b   (pad_b),
    .o_high_a  (high_a)
  );
  // ====================
  always #50 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_core_clk);
    i_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_core_clk);
    i_rd   <= 1'b0;
    @(negedge i_core_clk);
    d = o_rdata;
  endtask
  // Compare and counter are loaded in mode 0, where loading is immediate
  task automatic cfg(input tmw_row_type r);
    i_timer_tick_enable <= 1'b0;
    wr(tmw_pkg::ADDR_CTRL_B, 8'h00);
    wr(tmw_pkg::ADDR_CTRL_A, 8'h00);
    wr(tmw_pkg::ADDR_CMPA_H, 8'h00);
    wr(tmw_pkg::ADDR_CMPA_L, r.cmp);
    wr(tmw_pkg::ADDR_CNT_H, 8'h00);
    wr(tmw_pkg::ADDR_CNT_L, 8'h00);
    wr(tmw_pkg::ADDR_CTRL_B, r.cb);
    wr(tmw_pkg::ADDR_CTRL_A, r.ca);
    wr(tmw_pkg::ADDR_PIN_CTRL, {6'h00, r.dir});
  endtask
  // ====================
  initial begin
    repeat (2) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    rd(tmw_pkg::ADDR_CTRL_A, rv);
    chk({8'h00, rv}, 16'h0000);
    chk({13'h0000, o_flags, oe_a_n, oe_b_n}, 16'h0003);
    $display("reset values done");
    foreach (rows[k]) begin
      cfg(rows[k]);
      repeat (4) @(posedge i_core_clk);
      chk({14'h0, oe_a_n, oe_b_n}, {14'h0, rows[k].oe_n});
      if (rows[k].win != 12'h000) begin
        i_timer_tick_enable <= 1'b1;
        repeat (1024) @(posedge i_core_clk);
        h0 = high_a;
        repeat (rows[k].win) @(posedge i_core_clk);
        chk(high_a - h0, {4'h0, rows[k].hi});
      end
      $display("row %0d done", k);
    end
    chk({15'h0000, o_flags[0]}, 16'h0001);
    i_timer_tick_enable <= 1'b0;
    wr(tmw_pkg::ADDR_FLAGS, 8'h07);
    @(negedge i_core_clk);
    chk({13'h0000, o_flags}, 16'h0000);
    wr(tmw_pkg::ADDR_CTRL_A, 8'hff);
    rd(tmw_pkg::ADDR_CTRL_A, rv);
    chk({8'h00, rv}, 16'h00f3);
    wr(tmw_pkg::ADDR_CTRL_B, 8'hff);
    rd(tmw_pkg::ADDR_CTRL_B, rv);
    chk({8'h00, rv}, 16'h0058);
    rd(8'h90, rv);
    chk({8'h00, rv}, 16'h0000);
    $display("register masks done");
    i_timer_tick_enable <= 1'b1;
    repeat (20) @(posedge i_core_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    @(negedge i_core_clk);
    chk({14'h0, oe_a_n, oe_b_n}, 16'h0003);
    rd(tmw_pkg::ADDR_CTRL_A, rv);
    chk({8'h00, rv}, 16'h0000);
    $display("mid-run reset done");
    end_of_test();
  end
endmodule // tmw_timer16_waveform_bench
